/* bench/uafd_core_assertions.sv */
`timescale 1ns/1ps
module uafd_core_assertions import uafd_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [2:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic [7:0] bus_rdata_out,
    input wire logic serial_in_pin_in,
    input wire logic serial_out_pin_out
);
    // Shadows of control writes; the ports alone hide the settings
    logic tx_en, rx_en, dbl, filt;
    logic [2:0] size;
    logic [11:0] div;
    logic [5:0] quiet;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            {tx_en, rx_en, dbl, filt} <= 4'h0;
            size <= 3'h3;
            div <= 12'h000;
            quiet <= 6'h00;
        end else begin
            if (bus_wr_in && bus_addr_in == ADDR_CSA)
                {dbl, filt} <= bus_wdata_in[1:0];
            if (bus_wr_in && bus_addr_in == ADDR_CSB)
                {rx_en, tx_en, size[2]} <= bus_wdata_in[4:2];
            if (bus_wr_in && bus_addr_in == ADDR_CSC)
                size[1:0] <= bus_wdata_in[2:1];
            if (bus_wr_in && bus_addr_in == ADDR_BAUD_LO)
                div[7:0] <= bus_wdata_in;
            if (bus_wr_in && bus_addr_in == ADDR_BAUD_HI)
                div[11:8] <= bus_wdata_in[3:0];
            // High-run counter saturating at 63; a full count is the idle condition for the start check
            if (!serial_out_pin_out)
                quiet <= 6'h00;
            else if (quiet != 6'h3F)
                quiet <= quiet + 6'h01;
        end
    end
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);
    property p_rd_idle;
        !bus_rd_in |=> bus_rdata_out == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_unmapped;
        bus_rd_in && bus_addr_in > ADDR_BAUD_HI |=> bus_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_bit_len;
        $fell(serial_out_pin_out) |-> !serial_out_pin_out [*8];
    endproperty
    a_bit_len: assert property (p_bit_len)
        else $error("low bit shorter than eight clocks");
    property p_tx_start;
        bus_wr_in && bus_addr_in == ADDR_DATA && tx_en && div == 12'h000
            && quiet == 6'h3F |-> ##[1:4] !serial_out_pin_out;
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("frame did not start after data write");
    property p_upper;
        bus_rd_in && bus_addr_in == ADDR_DATA && size == 3'h0
            |=> bus_rdata_out[7:5] == 3'h0;
    endproperty
    a_upper: assert property (p_upper)
        else $error("unused upper bits not zero");
    property p_off_data;
        bus_rd_in && bus_addr_in == ADDR_DATA && !rx_en
            |=> bus_rdata_out == 8'h00;
    endproperty
    a_off_data: assert property (p_off_data)
        else $error("data left while receiver off");
    property p_off_flag;
        bus_rd_in && bus_addr_in == ADDR_CSA && !rx_en
            |=> {bus_rdata_out[7], bus_rdata_out[4:2]} == 4'h0;
    endproperty
    a_off_flag: assert property (p_off_flag)
        else $error("receive flags set while receiver off");
    property p_csa_ctrl;
        bus_rd_in && bus_addr_in == ADDR_CSA
            |=> bus_rdata_out[1:0] == {dbl, filt};
    endproperty
    a_csa_ctrl: assert property (p_csa_ctrl)
        else $error("filter or speed bit readback wrong");
    c_tx: cover property ($fell(serial_out_pin_out));
    c_rd: cover property (bus_rd_in && bus_addr_in == ADDR_DATA
        ##1 bus_rdata_out != 8'h00);
    c_filt: cover property (filt && bus_rd_in && bus_addr_in == ADDR_DATA);
endmodule

/* bench/uafd_core_tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    failures++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module uafd_core_tb_top import uafd_pkg::*;;
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [2:0] bus_addr_in = 3'h0;
    logic [7:0] bus_wdata_in = 8'h00;
    logic bus_wr_in = 1'b0;
    logic bus_rd_in = 1'b0;
    logic [7:0] bus_rdata_out;
    logic serial_in_pin_in;
    logic serial_out_pin_out;
    int failures = 0;
    int total_checks = 0;
    logic [7:0] rst_tab [8] = '{8'h00, 8'h20, 8'h00, 8'h06,
        8'h00, 8'h00, 8'h00, 8'h00};
    always #2 ref_clk_in = ~ref_clk_in;
    uafd_core dut (.ref_clk_in, .srst_in, .bus_addr_in, .bus_wdata_in,
        .bus_wr_in, .bus_rd_in, .bus_rdata_out, .serial_in_pin_in,
        .serial_out_pin_out);
    uafd_peer peer (.ref_clk_in, .dev_tx_in(serial_out_pin_out),
        .dev_rx_out(serial_in_pin_in));
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus_addr_in <= a;
        bus_wdata_in <= d;
        bus_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        bus_wr_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    // Transmit-complete masked unless the expectation sets it
    task automatic ck(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        bus_addr_in <= a;
        bus_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        bus_rd_in <= 1'b0;
        #1 v = bus_rdata_out;
        if (a == ADDR_CSA && !e[A_TX_DONE])
            v[A_TX_DONE] = 1'b0;
        `CHK(v, e)
        @(posedge ref_clk_in);
    endtask
    task automatic tx_wait(input logic [8:0] e);
        logic [8:0] g;
        for (int i = 0; i < 3000 && peer.got.size() == 0; i++)
            @(posedge ref_clk_in);
        g = (peer.got.size() != 0) ? peer.got.pop_front() : 9'bx;
        `CHK(g, e)
    endtask
    task automatic wrap_up();
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge ref_clk_in);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        @(posedge ref_clk_in);
        for (int a = 0; a < 8; a++)
            ck(a[2:0], rst_tab[a]);
        wr(ADDR_CSB, 8'h18);
        wr(ADDR_DATA, 8'hA5);
        repeat (2) @(posedge ref_clk_in);
        wr(ADDR_DATA, 8'h3C);
        wr(ADDR_DATA, 8'h0F);
        ck(ADDR_CSA, 8'h00);
        tx_wait(9'h0A5);
        tx_wait(9'h03C);
        repeat (400) @(posedge ref_clk_in);
        `CHK(peer.got.size(), 0)
        ck(ADDR_CSA, 8'h60);
        peer.send({2'b11, 8'h11}, 10, 1'b0);
        peer.send({2'b11, 8'h22}, 10, 1'b0);
        peer.send({2'b11, 8'h33}, 10, 1'b0);
        ck(ADDR_CSA, 8'hA0);
        ck(ADDR_DATA, 8'h11);
        ck(ADDR_DATA, 8'h22);
        ck(ADDR_CSA, 8'h20);
        ck(ADDR_DATA, 8'h00);
        wr(ADDR_CSC, 8'h00);
        peer.nb = 5;
        wr(ADDR_DATA, 8'hFF);
        tx_wait(9'h01F);
        peer.send({1'b1, 5'h1F}, 6, 1'b0);
        ck(ADDR_CSA, 8'hA8);
        ck(ADDR_DATA, 8'h1F);
        wr(ADDR_CSC, 8'h06);
        peer.nb = 8;
        wr(ADDR_CSA, 8'h01);
        peer.send({2'b10, 8'h44}, 10, 1'b0);
        ck(ADDR_CSA, 8'h21);
        peer.send({2'b11, 8'h55}, 10, 1'b0);
        ck(ADDR_CSA, 8'hA1);
        ck(ADDR_DATA, 8'h55);
        wr(ADDR_DATA, 8'h5A);
        tx_wait(9'h05A);
        wr(ADDR_CSB, 8'h1C);
        peer.nb = 9;
        peer.send({2'b10, 8'h66}, 10, 1'b0);
        ck(ADDR_CSA, 8'h21);
        peer.send({2'b11, 8'h77}, 10, 1'b0);
        ck(ADDR_CSB, 8'h1E);
        ck(ADDR_DATA, 8'h77);
        wr(ADDR_CSA, 8'h00);
        peer.send({2'b10, 8'h88}, 10, 1'b0);
        ck(ADDR_DATA, 8'h88);
        wr(ADDR_CSB, 8'h1D);
        wr(ADDR_DATA, 8'h99);
        tx_wait(9'h199);
        repeat (40) @(posedge ref_clk_in);
        wr(ADDR_CSB, 8'h18);
        peer.nb = 8;
        wr(ADDR_CSA, 8'h02);
        peer.bit_len = 8;
        peer.send({1'b1, 8'hC3}, 9, 1'b1);
        ck(ADDR_DATA, 8'hC3);
        wr(ADDR_DATA, 8'h96);
        tx_wait(9'h096);
        repeat (40) @(posedge ref_clk_in);
        wr(ADDR_CSA, 8'h00);
        peer.bit_len = 16;
        peer.send({1'b1, 8'h5A}, 9, 1'b1);
        ck(ADDR_DATA, 8'h5A);
        wr(ADDR_CSC, 8'h26);
        peer.nb = 9;
        wr(ADDR_DATA, 8'h07);
        tx_wait(9'h107);
        peer.send({2'b11, 8'h07}, 10, 1'b0);
        peer.send({2'b10, 8'h07}, 10, 1'b0);
        ck(ADDR_CSA, 8'hA0);
        ck(ADDR_DATA, 8'h07);
        ck(ADDR_CSA, 8'hA4);
        ck(ADDR_DATA, 8'h07);
        wr(ADDR_CSC, 8'h06);
        peer.nb = 8;
        peer.spike();
        ck(ADDR_CSA, 8'h20);
        peer.send({1'b1, 8'h3E}, 9, 1'b0);
        wr(ADDR_CSB, 8'h08);
        ck(ADDR_CSA, 8'h20);
        ck(ADDR_DATA, 8'h00);
        wrap_up();
    end
endmodule
bind uafd_core uafd_core_assertions chk (.ref_clk_in, .srst_in,
    .bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in, .bus_rdata_out,
    .serial_in_pin_in, .serial_out_pin_out);

/* bench/uafd_peer.sv */
`timescale 1ns/1ps
module uafd_peer (
    input wire logic ref_clk_in,
    input wire logic dev_tx_in,
    output logic dev_rx_out
);
    int bit_len = 16;
    int nb = 8;
    logic [8:0] got [$];
    initial dev_rx_out = 1'b1;
    // Start bit, then n bits of v LSB first; caller places the stops
    task automatic send(input logic [10:0] v, input int n, input bit g);
        logic b;
        for (int i = 0; i <= n; i++) begin
            b = (i == 0) ? 1'b0 : v[i-1];
            dev_rx_out <= b;
            repeat (bit_len / 2) @(posedge ref_clk_in);
            // One-cycle glitch spoils at most one of the three votes
            if (g)
                dev_rx_out <= ~b;
            @(posedge ref_clk_in);
            dev_rx_out <= b;
            repeat (bit_len / 2 - 1) @(posedge ref_clk_in);
        end
        dev_rx_out <= 1'b1;
        repeat (bit_len) @(posedge ref_clk_in);
    endtask
    task automatic spike();
        dev_rx_out <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        dev_rx_out <= 1'b1;
        repeat (40) @(posedge ref_clk_in);
    endtask
    initial forever begin : rx_side
        logic [8:0] d;
        @(negedge dev_tx_in);
        d = 9'h000;
        repeat (bit_len / 2) @(posedge ref_clk_in);
        for (int i = 0; i < nb; i++) begin
            repeat (bit_len) @(posedge ref_clk_in);
            d[i] = dev_tx_in;
        end
        got.push_back(d);
        repeat (bit_len) @(posedge ref_clk_in);
    end
endmodule

/* design/uafd_core.sv */
`timescale 1ns/1ps
//Contract
//- 16 samples per bit, 8 double speed
//- First vote sample 8, or 4 double
//- Middle vote sample 9, or 5 double
//- Data plus parity spans 5 to 10
//- Filter on drops non-address frames
//- Transmitter ignores the filter setting
//- Type bit: first stop, or ninth bit
//- Type one means address, zero data
//- Accepted address frame stored, flags normal
//- One data address: write tx, read rx
//- Unused upper bits ignored, read zero
//- Data write ignored while buffer full
//- Buffer loads shifter when empty, shifts out
//- Two-entry receive FIFO pops per read
//- Three centre samples majority vote
//- Start bit needs at most one high
//- Receiver disable empties FIFO at once
module uafd_core import uafd_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [2:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output logic [7:0] bus_rdata_out,
    input wire logic serial_in_pin_in,
    output logic serial_out_pin_out
);
    function automatic logic [3:0] char_bits(input logic [2:0] code);
        case (code)
            3'h0: char_bits = 4'h5;
            3'h1: char_bits = 4'h6;
            3'h2: char_bits = 4'h7;
            SIZE_NINE: char_bits = 4'h9;
            default: char_bits = 4'h8;
        endcase
    endfunction

    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // Serial input synchroniser and sample tick
    logic rx_meta, rx_pin;
    logic [11:0] baud_cnt, next_baud_cnt;
    logic tick, next_tick;

    // Software state
    logic addr_filter_enable, double_speed_select, tx_complete_flag;
    logic rx_en, tx_en, size2, tx_ninth_bit;
    logic [1:0] par_mode, size_low;
    logic stop_bits_select;
    logic [11:0] baud_divisor;
    logic next_addr_filter_enable, next_double_speed_select;
    logic next_tx_complete_flag, next_rx_en, next_tx_en, next_size2;
    logic next_tx_ninth_bit, next_stop_bits_select;
    logic [1:0] next_par_mode, next_size_low;
    logic [11:0] next_baud_divisor;

    // Receiver and FIFO
    uafd_rx_e rx_state, next_rx_state;
    logic [4:0] rx_cnt, next_rx_cnt;
    logic [1:0] rx_samp, next_rx_samp;
    logic [3:0] rx_idx, next_rx_idx;
    logic [10:0] rx_frame, next_rx_frame;
    logic dor_pend, next_dor_pend;
    logic [1:0][8:0] fifo_data, next_fifo_data;
    logic [1:0][2:0] fifo_err, next_fifo_err;
    logic [1:0] fifo_cnt, next_fifo_cnt;
    logic fifo_head, next_fifo_head;

    // Transmitter
    logic [8:0] tx_holding_reg, next_tx_holding_reg;
    logic tx_full, next_tx_full;
    logic [12:0] tx_sh, next_tx_sh;
    logic [3:0] tx_left, next_tx_left;
    logic [4:0] tx_cnt, next_tx_cnt;
    logic tx_live, next_tx_live;
    logic next_serial_out;
    logic [7:0] next_rdata;

    // Shared decode
    logic [3:0] nbits, rx_need, tx_len;
    logic [4:0] spb, s_first, s_mid;
    logic par_en, rx_bit, pop, push, frame_type, stop_bit, fe, pe;
    logic [1:0] cnt_after_pop;
    logic [10:0] f;
    logic [8:0] d;
    logic [12:0] tx_img;
    logic [8:0] head_data;
    logic [2:0] head_err;

    always_comb begin
        nbits = char_bits({size2, size_low});
        par_en = par_mode[1];
        spb = double_speed_select ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
        s_first = double_speed_select ? FIRST_DOUBLE : FIRST_NORMAL;
        s_mid = double_speed_select ? MID_DOUBLE : MID_NORMAL;
        // Data, parity and first stop; later stops are never sampled
        rx_need = nbits + {3'h0, par_en} + 4'h1;
        rx_bit = maj3({rx_pin, rx_samp});
        head_data = fifo_data[fifo_head];
        head_err = (fifo_cnt != 2'h0) ? fifo_err[fifo_head] : 3'h0;
        next_baud_cnt = baud_cnt - 12'h001;
        next_tick = 1'b0;
        if (baud_cnt == 12'h000) begin
            next_baud_cnt = baud_divisor;
            next_tick = 1'b1;
        end
        next_addr_filter_enable = addr_filter_enable;
        next_double_speed_select = double_speed_select;
        next_tx_complete_flag = tx_complete_flag;
        next_rx_en = rx_en;
        next_tx_en = tx_en;
        next_size2 = size2;
        next_tx_ninth_bit = tx_ninth_bit;
        next_par_mode = par_mode;
        next_size_low = size_low;
        next_stop_bits_select = stop_bits_select;
        next_baud_divisor = baud_divisor;
        next_tx_holding_reg = tx_holding_reg;
        next_tx_full = tx_full;
        next_rdata = 8'h00;
        if (bus_wr_in) begin
            case (bus_addr_in)
                ADDR_DATA: begin
                    if (!tx_full) begin
                        next_tx_holding_reg = {tx_ninth_bit, bus_wdata_in};
                        next_tx_full = 1'b1;
                    end
                end
                ADDR_CSA: begin
                    next_double_speed_select = bus_wdata_in[A_DOUBLE];
                    next_addr_filter_enable = bus_wdata_in[A_FILTER];
                    if (bus_wdata_in[A_TX_DONE]) begin
                        next_tx_complete_flag = 1'b0;
                    end
                end
                ADDR_CSB: begin
                    next_rx_en = bus_wdata_in[B_RX_EN];
                    next_tx_en = bus_wdata_in[B_TX_EN];
                    next_size2 = bus_wdata_in[B_SIZE2];
                    next_tx_ninth_bit = bus_wdata_in[B_TX_NINTH];
                end
                ADDR_CSC: begin
                    next_par_mode = bus_wdata_in[C_PAR_HI:C_PAR_LO];
                    next_stop_bits_select = bus_wdata_in[C_STOP2];
                    next_size_low = bus_wdata_in[C_SIZE1:C_SIZE0];
                end
                ADDR_BAUD_LO: next_baud_divisor[7:0] = bus_wdata_in;
                ADDR_BAUD_HI: next_baud_divisor[11:8] = bus_wdata_in[3:0];
                default: ;
            endcase
        end
        if (bus_rd_in) begin
            case (bus_addr_in)
                ADDR_DATA: begin
                    if (fifo_cnt != 2'h0) begin
                        next_rdata = head_data[7:0];
                    end
                end
                ADDR_CSA: next_rdata = {fifo_cnt != 2'h0, tx_complete_flag,
                    !tx_full, head_err, double_speed_select,
                    addr_filter_enable};
                ADDR_CSB: next_rdata = {3'h0, rx_en, tx_en, size2,
                    (fifo_cnt != 2'h0) & head_data[8], tx_ninth_bit};
                ADDR_CSC: next_rdata = {2'h0, par_mode, stop_bits_select,
                    size_low, 1'b0};
                ADDR_BAUD_LO: next_rdata = baud_divisor[7:0];
                ADDR_BAUD_HI: next_rdata = {4'h0, baud_divisor[11:8]};
                default: next_rdata = 8'h00;
            endcase
        end
        // Any data read pops, even one that only wanted a bit
        pop = bus_rd_in && (bus_addr_in == ADDR_DATA)
            && (fifo_cnt != 2'h0);
        cnt_after_pop = fifo_cnt - {1'b0, pop};
        next_fifo_head = fifo_head ^ pop;
        next_fifo_data = fifo_data;
        next_fifo_err = fifo_err;
        next_rx_state = rx_state;
        next_rx_cnt = rx_cnt;
        next_rx_samp = rx_samp;
        next_rx_idx = rx_idx;
        next_rx_frame = rx_frame;
        next_dor_pend = dor_pend;
        push = 1'b0;
        f = rx_frame;
        f[rx_idx] = rx_bit;
        d = f[8:0];
        for (int i = 0; i < 9; i++) begin
            if (i >= int'(nbits)) begin
                d[i] = 1'b0;
            end
        end
        stop_bit = f[rx_need - 4'h1];
        frame_type = (nbits == 4'h9) ? f[8] : stop_bit;
        fe = !stop_bit;
        pe = par_en & (^d ^ f[nbits] ^ par_mode[0]);
        if (tick && rx_state == RX_IDLE) begin
            if (!rx_pin) begin
                next_rx_state = RX_START;
                next_rx_cnt = 5'h02; // This edge was sample one
            end
        end else if (tick) begin
            next_rx_cnt = (rx_cnt == spb) ? 5'h01 : rx_cnt + 5'h01;
            if (rx_cnt == s_first) begin
                next_rx_samp[0] = rx_pin;
            end
            if (rx_cnt == s_mid) begin
                next_rx_samp[1] = rx_pin;
            end
            if (rx_cnt == s_mid + 5'h01) begin
                if (rx_state == RX_START) begin
                    next_rx_idx = 4'h0;
                    // Two or more high samples mean a noise spike
                    next_rx_state = rx_bit ? RX_IDLE : RX_BITS;
                end else begin
                    next_rx_frame = f;
                    next_rx_idx = rx_idx + 4'h1;
                    if (rx_idx == rx_need - 4'h1) begin
                        // Early return to idle allows the next start
                        next_rx_state = RX_IDLE;
                        if (addr_filter_enable && !frame_type) begin
                            push = 1'b0;
                        end else if (cnt_after_pop == 2'h2) begin
                            next_dor_pend = 1'b1;
                        end else begin
                            push = 1'b1;
                        end
                    end
                end
            end
        end
        next_fifo_cnt = cnt_after_pop + {1'b0, push};
        if (push) begin
            next_fifo_data[next_fifo_head ^ cnt_after_pop[0]] = d;
            next_fifo_err[next_fifo_head ^ cnt_after_pop[0]] =
                {fe, dor_pend, pe};
            next_dor_pend = 1'b0;
        end
        if (!next_rx_en) begin
            next_rx_state = RX_IDLE;
            next_fifo_cnt = 2'h0;
            next_dor_pend = 1'b0;
        end
        // Transmitter never looks at the address filter
        tx_img = 13'h1FFF;
        tx_img[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(nbits)) begin
                tx_img[i + 1] = tx_holding_reg[i];
            end
        end
        if (par_en) begin
            tx_img[nbits + 4'h1] = ^(tx_holding_reg & ~(9'h1FF << nbits))
                ^ par_mode[0];
        end
        tx_len = nbits + {3'h0, par_en} + {3'h0, stop_bits_select}
            + 4'h2;
        // Disable waits for pending and ongoing frames
        next_tx_live = tx_en | (tx_live & (tx_full | tx_left != 4'h0));
        next_tx_sh = tx_sh;
        next_tx_left = tx_left;
        next_tx_cnt = tx_cnt;
        if (tx_left == 4'h0) begin
            if (tx_full && (tx_live || tx_en)) begin
                next_tx_sh = tx_img;
                next_tx_left = tx_len;
                next_tx_cnt = 5'h01;
                next_tx_full = 1'b0;
            end
        end else if (tick) begin
            next_tx_cnt = tx_cnt + 5'h01;
            if (tx_cnt == spb) begin
                next_tx_cnt = 5'h01;
                next_tx_sh = {1'b1, tx_sh[12:1]};
                next_tx_left = tx_left - 4'h1;
                if (tx_left == 4'h1 && !tx_full) begin
                    next_tx_complete_flag = 1'b1;
                end
            end
        end
        next_serial_out = (next_tx_left != 4'h0) ? next_tx_sh[0] : 1'b1;
    end

    always_ff @(posedge ref_clk_in) begin
        rx_meta <= serial_in_pin_in;
        rx_pin <= rx_meta;
        if (srst_in) begin
            rx_meta <= 1'b1;
            rx_pin <= 1'b1;
            baud_cnt <= BAUD_RESET;
            tick <= 1'b0;
            addr_filter_enable <= 1'b0;
            double_speed_select <= 1'b0;
            tx_complete_flag <= 1'b0;
            rx_en <= 1'b0;
            tx_en <= 1'b0;
            size2 <= 1'b0;
            tx_ninth_bit <= 1'b0;
            par_mode <= 2'h0;
            size_low <= SIZE_LOW_RESET;
            stop_bits_select <= 1'b0;
            baud_divisor <= BAUD_RESET;
            rx_state <= RX_IDLE;
            rx_cnt <= 5'h00;
            rx_samp <= 2'h3;
            rx_idx <= 4'h0;
            rx_frame <= 11'h000;
            dor_pend <= 1'b0;
            fifo_data <= '0;
            fifo_err <= '0;
            fifo_cnt <= 2'h0;
            fifo_head <= 1'b0;
            tx_holding_reg <= 9'h000;
            tx_full <= 1'b0;
            tx_sh <= 13'h1FFF;
            tx_left <= 4'h0;
            tx_cnt <= 5'h00;
            tx_live <= 1'b0;
            serial_out_pin_out <= 1'b1;
            bus_rdata_out <= 8'h00;
        end else begin
            baud_cnt <= next_baud_cnt;
            tick <= next_tick;
            addr_filter_enable <= next_addr_filter_enable;
            double_speed_select <= next_double_speed_select;
            tx_complete_flag <= next_tx_complete_flag;
            rx_en <= next_rx_en;
            tx_en <= next_tx_en;
            size2 <= next_size2;
            tx_ninth_bit <= next_tx_ninth_bit;
            par_mode <= next_par_mode;
            size_low <= next_size_low;
            stop_bits_select <= next_stop_bits_select;
            baud_divisor <= next_baud_divisor;
            rx_state <= next_rx_state;
            rx_cnt <= next_rx_cnt;
            rx_samp <= next_rx_samp;
            rx_idx <= next_rx_idx;
            rx_frame <= next_rx_frame;
            dor_pend <= next_dor_pend;
            fifo_data <= next_fifo_data;
            fifo_err <= next_fifo_err;
            fifo_cnt <= next_fifo_cnt;
            fifo_head <= next_fifo_head;
            tx_holding_reg <= next_tx_holding_reg;
            tx_full <= next_tx_full;
            tx_sh <= next_tx_sh;
            tx_left <= next_tx_left;
            tx_cnt <= next_tx_cnt;
            tx_live <= next_tx_live;
            serial_out_pin_out <= next_serial_out;
            bus_rdata_out <= next_rdata;
        end
    end
endmodule

/* design/uafd_pkg.sv */
package uafd_pkg;
    // Register map
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_CSA = 3'h1;
    localparam logic [2:0] ADDR_CSB = 3'h2;
    localparam logic [2:0] ADDR_CSC = 3'h3;
    localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
    localparam logic [2:0] ADDR_BAUD_HI = 3'h5;
    // control_status_a fields
    localparam int A_RX_DONE = 7;
    localparam int A_TX_DONE = 6;
    localparam int A_TX_EMPTY = 5;
    localparam int A_FRAME_ERR = 4;
    localparam int A_OVERRUN = 3;
    localparam int A_PARITY_ERR = 2;
    localparam int A_DOUBLE = 1;
    localparam int A_FILTER = 0;
    // control_b fields
    localparam int B_RX_EN = 4;
    localparam int B_TX_EN = 3;
    localparam int B_SIZE2 = 2;
    localparam int B_RX_NINTH = 1;
    localparam int B_TX_NINTH = 0;
    // control_c fields
    localparam int C_PAR_HI = 5;
    localparam int C_PAR_LO = 4;
    localparam int C_STOP2 = 3;
    localparam int C_SIZE1 = 2;
    localparam int C_SIZE0 = 1;
    localparam logic [1:0] SIZE_LOW_RESET = 2'h3;
    localparam logic [11:0] BAUD_RESET = 12'h000;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    // Sampling figures
    localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
    localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
    localparam logic [4:0] FIRST_NORMAL = 5'h08;
    localparam logic [4:0] FIRST_DOUBLE = 5'h04;
    localparam logic [4:0] MID_NORMAL = 5'h09;
    localparam logic [4:0] MID_DOUBLE = 5'h05;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10
    } uafd_rx_e;
endpackage
